// ==== common/fanlim_pkg.sv ====
`default_nettype none
package fanlim_pkg;
  // ----------------------------------------------------------------
  // Register map (register indices, not byte addresses: byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RAMP_CTRL2 = 8'h63;
  localparam logic [7:0] IDX_MIN_DUTY1  = 8'h64;
  localparam logic [7:0] IDX_MIN_DUTY2  = 8'h65;
  localparam logic [7:0] IDX_MIN_DUTY3  = 8'h66;
  localparam logic [7:0] IDX_START_R1   = 8'h67;
  localparam logic [7:0] IDX_START_LOC  = 8'h68;
  localparam logic [7:0] IDX_START_R2   = 8'h69;
  localparam logic [7:0] IDX_CRIT_R1    = 8'h6a;
  localparam logic [7:0] IDX_CRIT_LOC   = 8'h6b;
  localparam logic [7:0] IDX_CRIT_R2    = 8'h6c;
  localparam logic [7:0] IDX_HYST_R1L   = 8'h6d;
  localparam logic [7:0] IDX_HYST_R2    = 8'h6e;
  localparam logic [7:0] IDX_FAN_CFG    = 8'h80;  // Lock, floor selects, span
  localparam logic [7:0] IDX_STATUS     = 8'h81;  // Read-only block state
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RATE3_LSB  = 0;
  localparam int SMOOTH3_B  = 3;
  localparam int RATE2_LSB  = 4;
  localparam int SMOOTH2_B  = 7;
  localparam int CFG_LOCK_B = 0;
  localparam int CFG_OTOE_B = 1;
  localparam int CFG_FLR_LSB  = 4;
  localparam int CFG_SPAN_LSB = 8;
  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RAMP_CTRL2 = 8'h00;
  localparam logic [7:0] RST_MIN_DUTY   = 8'h80;
  localparam logic [7:0] RST_START_TEMP = 8'h9a;
  localparam logic [7:0] RST_CRIT_LIM   = 8'ha4;
  localparam logic [7:0] RST_CRIT_ALT   = 8'hc8;
  localparam logic [7:0] RST_HYST_R1L   = 8'h44;
  localparam logic [7:0] RST_HYST_R2    = 8'h40;
  localparam logic [3:0] RST_SPAN       = 4'hc;
  localparam logic [7:0] CRIT_DISABLE   = 8'h80;
  localparam logic [7:0] DUTY_FULL      = 8'hff;
  // ----------------------------------------------------------------
  // Timing: ramp time slot; 35 s over 0xaa duty counts at step 1
  // ----------------------------------------------------------------
  localparam int  CLK_HZ      = 40_000_000;
  localparam int  SLOT_US     = 205_900;
  localparam longint SLOT_CYC = longint'(SLOT_US) * CLK_HZ / 1_000_000;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } fanlim_temps_t;
  typedef struct packed {
    logic [7:0] drive1;
    logic [7:0] drive2;
    logic [7:0] drive3;
  } fanlim_duty_t;
endpackage
`default_nettype wire

// ==== rtl/fanlim_top.sv ====
// Behaviour
// RULE1: Bits 2:0 of ramp control 2 set the output 3 ramp step.
// RULE2: Bits 6:4 of ramp control 2 set the output 2 ramp step.
// RULE3: Ramp codes 0..7 step duty by 1,2,3,4,8,12,24,48 per slot.
// RULE4: Code 000 ramps third-to-full in about 35 s, code 111 in 0.8 s.
// RULE5: Bit 3 enables smoothing on output 3; clear means jump.
// RULE6: Bit 7 enables smoothing on output 2; clear means jump.
// RULE7: Ramp control 2 resets to zero.
// RULE8: Lock bit set makes every register read-only; writes ignored.
// RULE9: Minimum duty scales linearly, 0x00 off to 0xff full.
// RULE10: Minimum duty registers reset to 0x80, half duty.
// RULE11: Above start temperature the fan runs minimum duty rising with span.
// RULE12: Three start temperature registers reset to 0x9a.
// RULE13: Any channel above its critical limit forces all outputs full.
// RULE14: Critical limit 0x80 disables that channel's fail-safe.
// RULE15: Fail-safe holds until temperature falls below limit minus hysteresis.
// RULE16: Overtemp pin, when enabled as output, pulls low on critical excess.
// RULE17: Critical limits reset to 0xa4; variant resets remote 2 to 0xc8.
// RULE18: Four-bit hysteresis per channel for start and critical release.
// RULE19: Per-output floor bit: below start minus hysteresis, zero or minimum.
// RULE20: All comparisons use the eight-bit reading encoding.
`default_nettype none
module fanlim_top
  import fanlim_pkg::*;
#(
  parameter bit     ALT_VARIANT = 1'b0,    // Remote 2 critical reset choice
  parameter longint SLOT_CYCLES = SLOT_CYC // Ramp slot length in clocks
) (
  input  wire logic                      i_clk,       // 40 MHz clock
  input  wire logic                      i_rst,       // Async reset, high
  input  wire logic                      i_psel,      // APB select
  input  wire logic                      i_penable,   // APB enable
  input  wire logic                      i_pwrite,    // APB write
  input  wire logic [11:0]               i_paddr,     // APB byte address
  input  wire logic [31:0]               i_pwdata,    // APB write data
  output logic                           o_pready,    // APB ready
  output logic      [31:0]               o_prdata,    // APB read data
  output logic                           o_pslverr,   // APB error
  input  wire fanlim_pkg::fanlim_temps_t i_temps,     // Measured readings
  output fanlim_pkg::fanlim_duty_t       o_duty,      // Fan drive duties
  output logic                           o_overtemp_pin_n  // Overtemp, low active
);
  import fanlim_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]  ramp_ctrl_q;
  logic [7:0]  min_duty_q [3];
  logic [7:0]  start_q    [3];   // 0 remote1, 1 local, 2 remote2
  logic [7:0]  crit_q     [3];
  logic [7:0]  hyst_r1l_q;
  logic [7:0]  hyst_r2_q;
  logic [11:0] cfg_q;
  logic [7:0]  temp   [3];
  logic [3:0]  hyst   [3];
  logic [2:0]  run_q, fail_q;
  logic [7:0]  duty_q [3];

  // Bus decode
  wire        acc     = i_psel && i_penable;
  wire        aligned = (i_paddr[1:0] == 2'b00);
  wire [7:0]  idx     = i_paddr[9:2];
  wire        hi_zero = (i_paddr[11:10] == 2'b00);
  wire        locked  = cfg_q[CFG_LOCK_B];
  wire        wr_ok   = acc && i_pwrite && !locked; // RULE8
  wire [7:0]  wd      = i_pwdata[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    hit = aligned && hi_zero && (a == want);
  endfunction

  wire mapped = hit(idx, IDX_RAMP_CTRL2) || hit(idx, IDX_HYST_R1L) ||
                hit(idx, IDX_HYST_R2) || hit(idx, IDX_FAN_CFG) ||
                hit(idx, IDX_STATUS) ||
                (aligned && hi_zero && idx >= IDX_MIN_DUTY1 && idx <= IDX_CRIT_R2);

  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !mapped;

  assign temp[0] = i_temps.remote1;
  assign temp[1] = i_temps.local_t;
  assign temp[2] = i_temps.remote2;
  assign hyst[0] = hyst_r1l_q[7:4];
  assign hyst[1] = hyst_r1l_q[3:0];
  assign hyst[2] = hyst_r2_q[7:4];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Single registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ramp_ctrl_q <= RST_RAMP_CTRL2;  // RULE7
      hyst_r1l_q  <= RST_HYST_R1L;
      hyst_r2_q   <= RST_HYST_R2;
      cfg_q       <= {RST_SPAN, 8'h00};
    end else if (wr_ok) begin
      if (hit(idx, IDX_RAMP_CTRL2)) begin
        ramp_ctrl_q <= wd;
      end else if (hit(idx, IDX_HYST_R1L)) begin
        hyst_r1l_q <= wd;
      end else if (hit(idx, IDX_HYST_R2)) begin
        hyst_r2_q <= {wd[7:4], 4'h0};
      end else if (hit(idx, IDX_FAN_CFG)) begin
        cfg_q <= {i_pwdata[11:4], 2'b00, i_pwdata[1:0]};
      end
    end
  end

  // Per-channel registers
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      localparam logic [7:0] CRIT_RST =
        (g == 2 && ALT_VARIANT) ? RST_CRIT_ALT : RST_CRIT_LIM;  // RULE17
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          min_duty_q[g] <= RST_MIN_DUTY;    // RULE10
          start_q[g]    <= RST_START_TEMP;  // RULE12
          crit_q[g]     <= CRIT_RST;        // RULE17
        end else if (wr_ok) begin
          if (hit(idx, IDX_MIN_DUTY1 + 8'(g))) begin
            min_duty_q[g] <= wd;
          end else if (hit(idx, IDX_START_R1 + 8'(g))) begin
            start_q[g] <= wd;
          end else if (hit(idx, IDX_CRIT_R1 + 8'(g))) begin
            crit_q[g] <= wd;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Channel state: running and fail-safe with hysteresis
  // ----------------------------------------------------------------
  logic [2:0] run_d, fail_d, crit_en, crit_hi;
  logic [8:0] start_lo [3];
  logic [8:0] crit_lo  [3];
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      start_lo[c] = {1'b0, start_q[c]} - {5'h00, hyst[c]};  // RULE18
      crit_lo[c]  = {1'b0, crit_q[c]} - {5'h00, hyst[c]};   // RULE18
      crit_en[c]  = (crit_q[c] != CRIT_DISABLE);            // RULE14
      crit_hi[c]  = crit_en[c] && (temp[c] > crit_q[c]);    // RULE20
      if (temp[c] > start_q[c]) begin
        run_d[c] = 1'b1;                                    // RULE11
      end else if (start_lo[c][8] || {1'b0, temp[c]} >= start_lo[c]) begin
        run_d[c] = run_q[c];
      end else begin
        run_d[c] = 1'b0;
      end
      if (!crit_en[c]) begin
        fail_d[c] = 1'b0;
      end else if (crit_hi[c]) begin
        fail_d[c] = 1'b1;                                   // RULE13
      end else if (!crit_lo[c][8] && {1'b0, temp[c]} < crit_lo[c]) begin
        fail_d[c] = 1'b0;                                   // RULE15
      end else begin
        fail_d[c] = fail_q[c];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q  <= 3'b000;
      fail_q <= 3'b000;
    end else begin
      run_q  <= run_d;
      fail_q <= fail_d;
    end
  end

  // ----------------------------------------------------------------
  // Target duty per output (output n follows channel n)
  // ----------------------------------------------------------------
  logic [7:0] target [3];
  logic [3:0] span;
  logic [4:0] span_step;
  assign span = cfg_q[CFG_SPAN_LSB +: 4];
  // Slope: wider span, fewer duty counts per degree
  assign span_step = 5'd16 - {1'b0, span};

  always_comb begin
    logic [15:0] over;
    logic [15:0] sum;
    over = 16'h0000;
    sum  = 16'h0000;
    for (int c = 0; c < 3; c++) begin
      over = (temp[c] > start_q[c]) ? 16'(temp[c] - start_q[c]) : 16'h0000;
      sum  = 16'(min_duty_q[c]) + 16'(over * span_step);     // RULE9 RULE11
      if (|fail_q) begin
        target[c] = DUTY_FULL;                                // RULE13
      end else if (run_q[c]) begin
        target[c] = (sum > 16'h00ff) ? DUTY_FULL : sum[7:0];  // RULE11
      end else if (cfg_q[CFG_FLR_LSB + c]) begin
        target[c] = min_duty_q[c];                            // RULE19
      end else begin
        target[c] = 8'h00;                                    // RULE19
      end
    end
  end

  // ----------------------------------------------------------------
  // Ramp slot timer and step decode
  // ----------------------------------------------------------------
  logic [31:0] slot_cnt_q;
  wire         slot_tick = (slot_cnt_q == 32'(SLOT_CYCLES - 1));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_cnt_q <= 32'h0000_0000;
    end else begin
      slot_cnt_q <= slot_tick ? 32'h0000_0000 : slot_cnt_q + 32'h0000_0001;  // RULE4
    end
  end

  function automatic logic [7:0] step_of(input logic [2:0] code);
    case (code)
      3'h0:    step_of = 8'h01;  // RULE3
      3'h1:    step_of = 8'h02;
      3'h2:    step_of = 8'h03;
      3'h3:    step_of = 8'h04;
      3'h4:    step_of = 8'h08;
      3'h5:    step_of = 8'h0c;
      3'h6:    step_of = 8'h18;
      default: step_of = 8'h30;
    endcase
  endfunction

  logic [2:0] smooth;
  logic [7:0] step [3];
  assign smooth[0] = 1'b0;
  assign smooth[1] = ramp_ctrl_q[SMOOTH2_B];               // RULE6
  assign smooth[2] = ramp_ctrl_q[SMOOTH3_B];               // RULE5
  assign step[0]   = 8'h01;
  assign step[1]   = step_of(ramp_ctrl_q[RATE2_LSB +: 3]); // RULE2
  assign step[2]   = step_of(ramp_ctrl_q[RATE3_LSB +: 3]); // RULE1

  // ----------------------------------------------------------------
  // Duty outputs: jump, or walk toward target one step per slot
  // ----------------------------------------------------------------
  logic [7:0] duty_d [3];
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      duty_d[c] = duty_q[c];
      if (!smooth[c] || (|fail_q)) begin
        duty_d[c] = target[c];
      end else if (slot_tick) begin
        if (target[c] > duty_q[c]) begin
          duty_d[c] = (target[c] - duty_q[c] > step[c]) ?
                      8'(duty_q[c] + step[c]) : target[c];   // RULE1 RULE2 RULE3
        end else if (target[c] < duty_q[c]) begin
          duty_d[c] = (duty_q[c] - target[c] > step[c]) ?
                      8'(duty_q[c] - step[c]) : target[c];
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      duty_q[0] <= 8'h00;
      duty_q[1] <= 8'h00;
      duty_q[2] <= 8'h00;
    end else begin
      duty_q[0] <= duty_d[0];
      duty_q[1] <= duty_d[1];
      duty_q[2] <= duty_d[2];
    end
  end

  assign o_duty = '{drive1: duty_q[0], drive2: duty_q[1], drive3: duty_q[2]};

  // Overtemp pin: registered, low while enabled and any channel is over
  logic ot_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ot_q <= 1'b0;
    end else begin
      ot_q <= cfg_q[CFG_OTOE_B] && (|crit_hi);  // RULE16
    end
  end
  assign o_overtemp_pin_n = !ot_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd8;
  always_comb begin
    rd8 = 8'h00;
    if (hit(idx, IDX_RAMP_CTRL2)) begin
      rd8 = ramp_ctrl_q;
    end else if (hit(idx, IDX_HYST_R1L)) begin
      rd8 = hyst_r1l_q;
    end else if (hit(idx, IDX_HYST_R2)) begin
      rd8 = hyst_r2_q;
    end else if (hit(idx, IDX_STATUS)) begin
      rd8 = {1'b0, ot_q, run_q, fail_q};
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (hit(idx, IDX_MIN_DUTY1 + 8'(c))) rd8 = min_duty_q[c];
        if (hit(idx, IDX_START_R1 + 8'(c)))  rd8 = start_q[c];
        if (hit(idx, IDX_CRIT_R1 + 8'(c)))   rd8 = crit_q[c];
      end
    end
  end
  assign o_prdata = hit(idx, IDX_FAN_CFG) ? {20'h00000, cfg_q} : {24'h000000, rd8};

endmodule // fanlim_top
`default_nettype wire

// ==== test/fanlim_sva.sv ====
`default_nettype none
module fanlim_sva
#(
  parameter bit ALT_VARIANT = 1'b0  // Remote 2 limit reset choice
) (
  input wire logic                      i_clk,           // Clock
  input wire logic                      i_rst,           // Async reset
  input wire logic                      i_psel,          // APB select
  input wire logic                      i_penable,       // APB enable
  input wire logic                      i_pwrite,        // APB write
  input wire logic [11:0]               i_paddr,         // APB address
  input wire logic [31:0]               i_pwdata,        // APB write data
  input wire logic                      o_pready,        // APB ready
  input wire logic [31:0]               o_prdata,        // APB read data
  input wire logic                      o_pslverr,       // APB error
  input wire fanlim_pkg::fanlim_temps_t i_temps,         // Readings
  input wire fanlim_pkg::fanlim_duty_t  o_duty,          // Duties
  input wire logic                      o_overtemp_pin_n // Overtemp pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import fanlim_pkg::*;

  logic [2:0][7:0] temp_v;  // [2] remote 1, [1] local, [0] remote 2
  logic [2:0][7:0] lim_q;   // Shadow of the critical limits
  logic [1:0]      cfg_q;   // Shadow of lock and pin enable
  logic [2:0]      over;
  logic [2:0]      atl;
  logic [2:0]      over_q;
  logic [9:0]      idx;
  logic            acc;
  logic            mapped;
  logic            wr_ok;
  logic            hot_oe;

  // Access decode
  assign temp_v = {i_temps.remote1, i_temps.local_t, i_temps.remote2};
  assign idx    = i_paddr[11:2];
  assign acc    = i_psel && i_penable;
  assign mapped = (i_paddr[1:0] == 2'b00) && (idx inside {[10'h063:10'h06e], 10'h080, 10'h081});
  assign wr_ok  = acc && i_pwrite && mapped && !cfg_q[0];
  assign hot_oe = (over != 3'b000) && cfg_q[1];

  // Limit compare per channel; code 0x80 switches a channel off
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      over[k] = (temp_v[k] > lim_q[k]) && (lim_q[k] != CRIT_DISABLE);
      atl[k]  = (temp_v[k] >= lim_q[k]) && (lim_q[k] != CRIT_DISABLE);
    end
  end

  // Shadow state; a set lock freezes it like the registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lim_q  <= {RST_CRIT_LIM, RST_CRIT_LIM, ALT_VARIANT ? RST_CRIT_ALT : RST_CRIT_LIM};
      cfg_q  <= 2'b00;
      over_q <= 3'b000;
    end else begin
      over_q <= over;
      if (wr_ok && idx == 10'(IDX_FAN_CFG)) begin
        cfg_q <= i_pwdata[1:0];
      end
      for (int k = 0; k < 3; k++) begin
        if (wr_ok && idx == 10'(IDX_CRIT_R1) + 10'(k)) begin
          lim_q[2 - k] <= i_pwdata[7:0];
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_hold;
    (over != 3'b000) ##1 ((over_q & atl) != 3'b000);
  endsequence

  a_zero_wait: assert property (s_setup ##1 i_penable |-> o_pready)
    else $error("Access phase without ready");
  a_unmapped_err: assert property (acc && !mapped |-> o_pslverr && (i_pwrite || o_prdata == 0))
    else $error("Unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !o_pslverr)
    else $error("Mapped access refused");
  a_read_limit: assert property (
    acc && !i_pwrite && mapped && idx == 10'(IDX_CRIT_LOC) |-> o_prdata == {24'h0, lim_q[1]})
    else $error("Local limit readback wrong");
  a_fail_full: assert property ((over != 3'b000) |-> ##2 o_duty == 24'hffffff)
    else $error("Full duty missing after limit exceeded");
  a_fail_hold: assert property (s_hold |-> ##2 o_duty == 24'hffffff)
    else $error("Full duty released too early");
  a_pin_low: assert property (hot_oe |=> !o_overtemp_pin_n)
    else $error("Overtemp pin not asserted");
  a_pin_cause: assert property ($fell(o_overtemp_pin_n) |-> $past(hot_oe))
    else $error("Overtemp pin asserted without cause");
endmodule // fanlim_sva

bind fanlim_top fanlim_sva #(.ALT_VARIANT(ALT_VARIANT)) u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_temps(i_temps), .o_duty(o_duty), .o_overtemp_pin_n(o_overtemp_pin_n)
);
`default_nettype wire

// ==== test/fanlim_fan_model.sv ====
`default_nettype none
module fanlim_fan_model (
  input  wire logic                     i_clk,   // Bench clock
  input  wire logic                     i_rst,   // Reset, high
  input  wire fanlim_pkg::fanlim_duty_t i_duty,  // Drive duty codes
  output var  fanlim_pkg::fanlim_duty_t o_speed  // Rotor speed, 0x00 stop to 0xff full
);
  timeunit 1ns;
  timeprecision 1ps;
  import fanlim_pkg::*;

  // Rotor inertia: speed creeps one count a cycle toward the drive
  function automatic logic [7:0] spin(input logic [7:0] sp, input logic [7:0] d);
    return (sp < d) ? sp + 8'h01 : (sp > d) ? sp - 8'h01 : sp;
  endfunction

  // Speed follows the duty code linearly
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_speed <= '0;
    end else begin
      o_speed <= {spin(o_speed.drive1, i_duty.drive1), spin(o_speed.drive2, i_duty.drive2),
                  spin(o_speed.drive3, i_duty.drive3)};
    end
  end
endmodule // fanlim_fan_model
`default_nettype wire

// ==== test/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fanlim_pkg::*;

  localparam int STEPS [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  logic          clk;
  logic          rst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic          pin_n;
  fanlim_temps_t temps;
  fanlim_duty_t  duty;
  fanlim_duty_t  speed;
  int            err_total;
  int            n_tests;
  int            n;
  int            m;
  int            k;
  int            s;

  fanlim_top #(.SLOT_CYCLES(8)) uut (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_temps(temps), .o_duty(duty), .o_overtemp_pin_n(pin_n));
  fanlim_fan_model u_fans (.i_clk(clk), .i_rst(rst), .i_duty(duty), .o_speed(speed));

  // Expected reset value of a register index
  function automatic logic [31:0] rst_of(input logic [7:0] i);
    return (i == 8'h63) ? 32'h00 : (i <= 8'h66) ? 32'h80 : (i <= 8'h69) ? 32'h9a : 32'ha4;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  // One APB transfer; held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, i, 32'h0, r, e);
    chk(r, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "slave error");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog, well past the expected run
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    conclude();
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    temps = 24'h202020;
    void'($urandom(14447));
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    for (int i = 8'h63; i <= 8'h6c; i++) begin
      rdc(8'(i), rst_of(8'(i)), 1'b0);
    end
    rdc(IDX_HYST_R1L, {24'h0, RST_HYST_R1L}, 1'b0);
    rdc(IDX_HYST_R2, {24'h0, RST_HYST_R2}, 1'b0);
    rdc(IDX_FAN_CFG, {20'h0, RST_SPAN, 8'h00}, 1'b0);
    rdc(8'h01, 32'h0, 1'b1);
    $display("test reset and map done");
    for (int c = 0; c < 8; c++) begin
      s = STEPS[c];
      m = (160 + s - 1) / s;
      wr(IDX_RAMP_CTRL2, {24'h0, 1'b1, 3'(c), 1'b1, 3'(c)});
      temps <= 24'h20a2a2;
      n = 0;
      while (duty.drive3 === 8'h00 && n < 40) begin
        @(posedge clk);
        n++;
      end
      chk({8'h0, duty}, {16'h0, s[7:0], s[7:0]}, "first ramp step");
      while (duty.drive3 !== 8'ha0 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      chk({31'h0, n >= (m - 1) * 8 && n <= m * 8 + 4}, 32'h1, "ramp time");
      chk({8'h0, duty}, 32'h00a0a0, "ramp end");
      temps <= 24'h202020;
      n = 0;
      while (duty !== 24'h0 && n < 1500) begin
        @(posedge clk);
        n++;
      end
      chk({8'h0, duty}, 32'h0, "ramp down");
    end
    wr(IDX_RAMP_CTRL2, 32'h0);
    temps <= 24'h20a2a2;
    cyc(3);
    chk({8'h0, duty}, 32'h00a0a0, "unsmoothed jump");
    temps <= 24'h202020;
    $display("test ramp done");
    for (int j = 0; j < 4; j++) begin
      m = $urandom_range(64, 0);
      k = $urandom_range(8, 1);
      wr(IDX_MIN_DUTY1, 32'(m));
      rdc(IDX_MIN_DUTY1, 32'(m), 1'b0);
      temps.remote1 <= 8'(154 + k);
      cyc(3);
      chk({8'h0, duty}, {8'h0, 8'(m + 4 * k), 16'h0}, "running duty");
    end
    $display("test minimum duty done");
    temps <= 24'h202020;
    wr(IDX_FAN_CFG, 32'hc02);
    wr(IDX_CRIT_LOC, 32'h80);
    temps.local_t <= 8'hb0;
    cyc(3);
    chk({7'h0, duty, pin_n}, {7'h0, 24'h00d800, 1'b1}, "limit off");
    temps.remote1 <= 8'ha5;
    cyc(3);
    chk({7'h0, duty, pin_n}, {7'h0, 24'hffffff, 1'b0}, "fail-safe");
    temps.remote1 <= 8'ha4;
    cyc(260);
    chk({8'h0, speed}, 32'hffffff, "fans at full");
    temps.remote1 <= 8'ha1;
    cyc(3);
    chk({7'h0, duty, pin_n}, {7'h0, 24'hffffff, 1'b1}, "hold");
    temps.remote1 <= 8'h9f;
    cyc(3);
    chk({7'h0, duty, pin_n}, {7'h0, 8'(m + 20), 16'hd800, 1'b1}, "release");
    temps.remote1 <= 8'h97;
    cyc(3);
    chk({8'h0, duty}, {8'h0, 8'(m), 16'hd800}, "start hysteresis hold");
    temps.remote1 <= 8'h95;
    cyc(3);
    chk({8'h0, duty}, 32'h00d800, "start hysteresis off");
    wr(IDX_FAN_CFG, 32'hc12);
    cyc(2);
    chk({8'h0, duty}, {8'h0, 8'(m), 16'hd800}, "floor at minimum");
    $display("test fail-safe done");
    wr(IDX_FAN_CFG, 32'hc03);
    wr(IDX_MIN_DUTY1, 32'hff);
    wr(IDX_FAN_CFG, 32'h0);
    rdc(IDX_MIN_DUTY1, 32'(m), 1'b0);
    rdc(IDX_FAN_CFG, 32'hc03, 1'b0);
    $display("test lock done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
